// >>> rtl/cpar_regs.v
// register bank of the first copper port's auto-negotiation management
`timescale 1ns/1ns
`include "cpar_defs.vh"
module cpar_regs #(
  parameter ADDR_W = 8,
  parameter DATA_W = 16
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  // management register port, fed by the serial management front end
  input wire [ADDR_W-1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [DATA_W-1:0] i_reg_wdata,
  input wire i_reg_rd,
  output reg [DATA_W-1:0] o_reg_rdata,
  output wire o_reg_rvalid,
  // negotiation engine, same clock
  input wire i_lp_page_valid,
  input wire [DATA_W-1:0] i_lp_page,
  input wire i_pd_fault,
  input wire i_lp_an_able,
  // copper port status, same clock
  input wire i_link_up,
  input wire i_full_duplex,
  input wire i_speed_100,
  input wire i_remote_power_abn,
  // towards the negotiation engine and basic status
  output wire [DATA_W-1:0] o_adv_page,
  output wire o_remote_fault_status,
  // towards the copper front end
  output wire o_auto_xover_en,
  output wire o_heartbeat_en,
  output wire o_jabber_en,
  output wire o_fef_en,
  output wire o_power_save_en,
  output wire o_normal_link_pulse_en,
  output wire o_dsp_restart_bypass,
  output wire o_coder_bypass,
  output wire o_scrambler_bypass,
  output wire o_int
);

  // =====================================================================
  // storage
  reg [DATA_W-1:0] adv_r;
  reg [DATA_W-1:0] lp_page_r;
  reg lp_an_able_r;
  reg [DATA_W-1:0] spec_ctrl_r;
  reg gmask_r;
  reg [2:0] chg_mask_r;
  reg power_en_r;
  reg link_prev_r;
  reg duplex_prev_r;
  reg speed_prev_r;
  reg primed_r;
  reg rvalid_r;

  // interrupt reset pieces, cut from the full reset word so that the
  // stored mask bits and the read view can never disagree after reset
  localparam [15:0] INT_RST = `CPAR_RST_INT;
  localparam [0:0] GMASK_RST = INT_RST[`CPAR_INT_GLOBAL_MASK];
  localparam [2:0] CHG_MASK_RST = INT_RST[`CPAR_INT_MASK_SPEED:`CPAR_INT_MASK_LINK];
  localparam [0:0] POWER_EN_RST = INT_RST[`CPAR_INT_EN_POWER];

  wire [`CPAR_NUM_STICKY-1:0] stk_set;
  wire [`CPAR_NUM_STICKY-1:0] stk_clr;
  wire [`CPAR_NUM_STICKY-1:0] stk_q;

  wire wr_en;
  wire rd_en;
  wire rd_exp;
  wire rd_int;
  wire [DATA_W-1:0] exp_val;
  wire [DATA_W-1:0] int_val;
  wire [4:0] int_low_flags;
  wire link_chg;
  wire duplex_chg;
  wire speed_chg;

  reg [DATA_W-1:0] rd_mux;

  // =====================================================================
  // access strobes; a frozen clock enable also freezes bus side effects
  // a read and a write in one cycle both act; the read shows the old value
  assign wr_en = i_reg_wr & i_ce;
  assign rd_en = i_reg_rd & i_ce;
  assign rd_exp = rd_en & (i_reg_addr == `CPAR_ADDR_EXPANSION);
  assign rd_int = rd_en & (i_reg_addr == `CPAR_ADDR_INT);

  // =====================================================================
  // advertisement register
  // only remote fault, pause, technology and selector bits take writes
  // the selector is stored as written; an unknown code is the manager's concern
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      adv_r <= `CPAR_RST_ADVERTISE;
    end else if (wr_en && i_reg_addr == `CPAR_ADDR_ADVERTISE) begin
      adv_r <= i_reg_wdata & `CPAR_ADV_WR_MASK;
    end
  end

  // the page offered to the partner is the advertisement as stored;
  // bits 15, 14 and 12 never leave as ones
  assign o_adv_page = adv_r;

  // =====================================================================
  // partner base page capture
  // page and valid share one edge, so a half-updated page is never read back
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lp_page_r <= `CPAR_RST_PARTNER;
      lp_an_able_r <= 1'b0;
    end else if (i_ce) begin
      lp_an_able_r <= i_lp_an_able;
      if (i_lp_page_valid) begin
        lp_page_r <= i_lp_page;
      end
    end
  end

  // remote fault seen in the partner page goes on to basic status
  assign o_remote_fault_status = lp_page_r[`CPAR_LP_REMOTE_FAULT];

  // =====================================================================
  // status change detection; the first enabled cycle after reset only
  // primes the history so that default levels raise no false change
  // limitation: a level that toggles and returns is two changes but one
  // flag; only the fact of a change survives until the read, not the count
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_prev_r <= 1'b0;
      duplex_prev_r <= 1'b0;
      speed_prev_r <= 1'b0;
      primed_r <= 1'b0;
    end else if (i_ce) begin
      link_prev_r <= i_link_up;
      duplex_prev_r <= i_full_duplex;
      speed_prev_r <= i_speed_100;
      primed_r <= 1'b1;
    end
  end

  assign link_chg = primed_r & (link_prev_r ^ i_link_up);
  assign duplex_chg = primed_r & (duplex_prev_r ^ i_full_duplex);
  assign speed_chg = primed_r & (speed_prev_r ^ i_speed_100);

  // =====================================================================
  // latch-high flags: set by events, cleared by reading their register
  assign stk_set[`CPAR_STK_PD_FAULT] = i_pd_fault;
  assign stk_set[`CPAR_STK_PAGE_RX] = i_lp_page_valid;
  assign stk_set[`CPAR_STK_LINK] = link_chg;
  assign stk_set[`CPAR_STK_DUPLEX] = duplex_chg;
  assign stk_set[`CPAR_STK_SPEED] = speed_chg;
  assign stk_set[`CPAR_STK_POWER] = i_remote_power_abn;
  assign stk_clr[`CPAR_STK_PD_FAULT] = rd_exp;
  assign stk_clr[`CPAR_STK_PAGE_RX] = rd_exp;
  assign stk_clr[`CPAR_STK_LINK] = rd_int;
  assign stk_clr[`CPAR_STK_DUPLEX] = rd_int;
  assign stk_clr[`CPAR_STK_SPEED] = rd_int;
  assign stk_clr[`CPAR_STK_POWER] = rd_int;

  // one flag instance per event keeps set-over-clear identical for every bit
  genvar gi;
  generate
    for (gi = 0; gi < `CPAR_NUM_STICKY; gi = gi + 1) begin : g_stk
      cpar_sticky u_stk (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_set(stk_set[gi]),
        .i_clr(stk_clr[gi]),
        .o_q(stk_q[gi])
      );
    end
  endgenerate

  // =====================================================================
  // expansion register view; upper bits read as zero
  assign exp_val = {
    11'h000,
    stk_q[`CPAR_STK_PD_FAULT],
    lp_page_r[`CPAR_LP_NEXT_PAGE],
    1'b1,
    stk_q[`CPAR_STK_PAGE_RX],
    lp_an_able_r
  };

  // =====================================================================
  // specific control register, fully stored as written
  // the top and bottom fields are kept by software at zero; they are
  // stored so a read shows what was written, but only bit 15 acts
  // nothing here self-clears; software restores defaults by writing zero
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spec_ctrl_r <= `CPAR_RST_SPEC_CTRL;
    end else if (wr_en && i_reg_addr == `CPAR_ADDR_SPEC_CTRL) begin
      spec_ctrl_r <= i_reg_wdata;
    end
  end

  // control decode towards the front end
  assign o_auto_xover_en = ~spec_ctrl_r[`CPAR_SC_XOVER_DIS];
  assign o_heartbeat_en = spec_ctrl_r[`CPAR_SC_HEARTBEAT_EN];
  assign o_jabber_en = spec_ctrl_r[`CPAR_SC_JABBER_EN];
  assign o_fef_en = ~spec_ctrl_r[`CPAR_SC_FEF_DIS];
  assign o_power_save_en = ~spec_ctrl_r[`CPAR_SC_PSAVE_DIS];
  assign o_normal_link_pulse_en = ~spec_ctrl_r[`CPAR_SC_LINK_PULSE_DIS];
  assign o_dsp_restart_bypass = spec_ctrl_r[`CPAR_SC_RESTART_BYP];
  // coder and scrambler bypasses are test features, inert unless the top bit opens them
  assign o_coder_bypass = spec_ctrl_r[`CPAR_SC_TEST_EN] &
                          spec_ctrl_r[`CPAR_SC_CODER_BYP];
  assign o_scrambler_bypass = spec_ctrl_r[`CPAR_SC_TEST_EN] &
                              spec_ctrl_r[`CPAR_SC_SCRAM_BYP];

  // =====================================================================
  // interrupt mask bits; reserved bits 12 and 11 read their reset ones
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gmask_r <= GMASK_RST;
      chg_mask_r <= CHG_MASK_RST;
      power_en_r <= POWER_EN_RST;
    end else if (wr_en && i_reg_addr == `CPAR_ADDR_INT) begin
      gmask_r <= i_reg_wdata[`CPAR_INT_GLOBAL_MASK];
      chg_mask_r <= i_reg_wdata[`CPAR_INT_MASK_SPEED:`CPAR_INT_MASK_LINK];
      power_en_r <= i_reg_wdata[`CPAR_INT_EN_POWER];
    end
  end

  // five lowest flags; bits 4 and 3 are reserved zeros
  assign int_low_flags = {
    2'h0,
    stk_q[`CPAR_STK_SPEED],
    stk_q[`CPAR_STK_DUPLEX],
    stk_q[`CPAR_STK_LINK]
  };

  // interrupt register view
  assign int_val = {
    2'h0,
    gmask_r,
    1'b1,
    1'b1,
    chg_mask_r,
    power_en_r,
    stk_q[`CPAR_STK_POWER],
    |int_low_flags,
    int_low_flags
  };

  // pin is active high; the global mask overrides every individual one
  // a flag raised while masked still stands, so unmasking it later
  // raises the pin at once unless the register is read first
  assign o_int = ~gmask_r & (
    (stk_q[`CPAR_STK_LINK] & ~chg_mask_r[0]) |
    (stk_q[`CPAR_STK_DUPLEX] & ~chg_mask_r[1]) |
    (stk_q[`CPAR_STK_SPEED] & ~chg_mask_r[2]) |
    (stk_q[`CPAR_STK_POWER] & power_en_r));

  // =====================================================================
  // read multiplexer; unused and core-reserved locations return zero
  // and have no side effect, so a scan of those locations clears no flag
  always @* begin
    rd_mux = 16'h0000;
    case (i_reg_addr)
      `CPAR_ADDR_ADVERTISE: begin
        rd_mux = adv_r;
      end
      `CPAR_ADDR_PARTNER: begin
        rd_mux = lp_page_r & ~(16'h0001 << `CPAR_LP_RSVD);
      end
      `CPAR_ADDR_EXPANSION: begin
        rd_mux = exp_val;
      end
      `CPAR_ADDR_SPEC_CTRL: begin
        rd_mux = spec_ctrl_r;
      end
      `CPAR_ADDR_INT: begin
        rd_mux = int_val;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // read data is registered; the value shown is the one before the
  // clear that the same read performs
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
      rvalid_r <= 1'b0;
    end else if (i_ce) begin
      rvalid_r <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  assign o_reg_rvalid = rvalid_r;

endmodule // cpar_regs

// >>> rtl/cpar_defs.vh
// constants for the copper port auto-negotiation register bank
// Operation
// - advertised next-page bit reads zero, ignores writes
// - reserved advertisement bits written zero, read ignored
// - remote-fault bit advertises local fault, resets zero
// - asymmetric pause resets zero, symmetric pause one
// - T4 resets zero, other technology bits one
// - five-bit selector field resets to one
// - partner page read-only, zero reset, captured
// - partner remote fault raises basic status fault
// - partner page reserved bit always reads zero
// - expansion resets four, parallel fault latches high
// - page-received bit latches high on new page
// - partner abilities reported, local next-page reads one
// - unused and core-reserved locations not generally defined
// - crossover-disable bit turns off automatic pair selection
// - heartbeat and jabber enables reset disabled
// - far-end-fault disable bit stops fault signalling
// - power-save disable bit stops analog power save
// - link-pulse disable stops normal link pulses
// - restart-bypass skips core restart in coding sublayer
// - coder/scrambler bypass valid only with top bit
// - interrupt reset value; global mask masks all
// - low flags mark changes, drive pin, clear-on-read
// - summary bit is OR of five lowest flags
`ifndef CPAR_DEFS_VH
`define CPAR_DEFS_VH

// =====================================================================
// register offsets
`define CPAR_ADDR_ADVERTISE 8'hc4
`define CPAR_ADDR_PARTNER 8'hc5
`define CPAR_ADDR_EXPANSION 8'hc6
`define CPAR_ADDR_UNUSED_LO 8'hc7
`define CPAR_ADDR_UNUSED_HI 8'hc8
`define CPAR_ADDR_CORE_LO 8'hc9
`define CPAR_ADDR_CORE_HI 8'hcf
`define CPAR_ADDR_SPEC_CTRL 8'hd0
`define CPAR_ADDR_INT 8'hd1

// =====================================================================
// reset values
`define CPAR_RST_ADVERTISE 16'h05e1
`define CPAR_RST_PARTNER 16'h0000
`define CPAR_RST_EXPANSION 16'h0004
`define CPAR_RST_SPEC_CTRL 16'h0000
`define CPAR_RST_INT 16'h3f00

// =====================================================================
// advertisement fields
`define CPAR_ADV_NEXT_PAGE 15
`define CPAR_ADV_RSVD_HI 14
`define CPAR_ADV_REMOTE_FAULT 13
`define CPAR_ADV_RSVD_LO 12
`define CPAR_ADV_WR_MASK 16'h2fff

// =====================================================================
// partner page and expansion fields
`define CPAR_LP_REMOTE_FAULT 13
`define CPAR_LP_RSVD 12
`define CPAR_LP_NEXT_PAGE 15
`define CPAR_EXP_PD_FAULT 4
`define CPAR_EXP_LP_NP_ABLE 3
`define CPAR_EXP_LOCAL_NP 2
`define CPAR_EXP_PAGE_RX 1
`define CPAR_EXP_LP_AN_ABLE 0

// =====================================================================
// specific control fields
`define CPAR_SC_TEST_EN 15
`define CPAR_SC_XOVER_DIS 11
`define CPAR_SC_HEARTBEAT_EN 10
`define CPAR_SC_JABBER_EN 9
`define CPAR_SC_FEF_DIS 8
`define CPAR_SC_PSAVE_DIS 7
`define CPAR_SC_LINK_PULSE_DIS 6
`define CPAR_SC_RESTART_BYP 5
`define CPAR_SC_CODER_BYP 4
`define CPAR_SC_SCRAM_BYP 3

// =====================================================================
// interrupt register fields
`define CPAR_INT_GLOBAL_MASK 13
`define CPAR_INT_RSVD_MASK 12
`define CPAR_INT_RSVD_11 11
`define CPAR_INT_MASK_SPEED 10
`define CPAR_INT_MASK_DUPLEX 9
`define CPAR_INT_MASK_LINK 8
`define CPAR_INT_EN_POWER 7
`define CPAR_INT_POWER 6
`define CPAR_INT_SUMMARY 5
`define CPAR_INT_SPEED 2
`define CPAR_INT_DUPLEX 1
`define CPAR_INT_LINK 0

// sticky flag slots
`define CPAR_NUM_STICKY 6
`define CPAR_STK_PD_FAULT 0
`define CPAR_STK_PAGE_RX 1
`define CPAR_STK_LINK 2
`define CPAR_STK_DUPLEX 3
`define CPAR_STK_SPEED 4
`define CPAR_STK_POWER 5

`endif

// >>> rtl/cpar_sticky.v
// latch-high flag: hardware sets, a read clears, set wins over clear
`timescale 1ns/1ns
module cpar_sticky (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_set,
  input wire i_clr,
  output wire o_q
);

  reg q_r;
  reg q_nxt;

  // =====================================================================
  // next value: an event in the clearing cycle must not be lost
  always @* begin
    q_nxt = q_r;
    if (i_clr) begin
      q_nxt = 1'b0;
    end
    if (i_set) begin
      q_nxt = 1'b1;
    end
  end

  // flag storage
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_r <= 1'b0;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule // cpar_sticky

// >>> dv/cpar_regs_monitor.sv
// assertion checker for the copper port negotiation register bank
`timescale 1ns/1ns
module cpar_regs_monitor #(
  parameter ADDR_W = 8,
  parameter DATA_W = 16
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire [ADDR_W-1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [DATA_W-1:0] i_reg_wdata,
  input wire i_reg_rd,
  input wire [DATA_W-1:0] o_reg_rdata,
  input wire o_reg_rvalid,
  input wire i_lp_page_valid,
  input wire [DATA_W-1:0] i_lp_page,
  input wire [DATA_W-1:0] o_adv_page,
  input wire o_remote_fault_status,
  input wire o_auto_xover_en,
  input wire o_fef_en,
  input wire o_power_save_en,
  input wire o_normal_link_pulse_en,
  input wire o_dsp_restart_bypass,
  input wire o_coder_bypass,
  input wire o_scrambler_bypass,
  input wire o_int
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // =====================================================================
  // decoded requests
  wire rd_go = i_ce && i_reg_rd;
  wire rd_c6 = rd_go && (i_reg_addr == 8'hc6);
  wire wr_ctl = i_ce && i_reg_wr && (i_reg_addr == 8'hd0);
  wire wr_int = i_ce && i_reg_wr && (i_reg_addr == 8'hd1);
  wire mapped = (i_reg_addr == 8'hc4) || (i_reg_addr == 8'hc5) || (i_reg_addr == 8'hc6) ||
    (i_reg_addr == 8'hd0) || (i_reg_addr == 8'hd1);
  // =====================================================================
  // assertions
  a_adv_fixed_zero: assert property (o_adv_page[15:14] == 2'b00 && !o_adv_page[12])
    else $error("advertised fixed bits not zero");
  a_read_answer: assert property (rd_go |=> o_reg_rvalid) else $error("read not answered");
  a_rvalid_quiet: assert property (i_ce && !i_reg_rd |=> !o_reg_rvalid)
    else $error("stray read valid");
  a_rvalid_frozen: assert property (!i_ce |=> $stable(o_reg_rvalid) && $stable(o_reg_rdata))
    else $error("read port moved while frozen");
  a_xover_follows: assert property (wr_ctl |=> o_auto_xover_en == !$past(i_reg_wdata[11]))
    else $error("crossover enable wrong");
  a_fault_sigs_follow: assert property (wr_ctl |=>
    {o_fef_en, o_power_save_en, o_normal_link_pulse_en, o_dsp_restart_bypass} ==
    ($past(i_reg_wdata[8:5]) ^ 4'b1110)) else $error("front end controls wrong");
  a_bypass_gated: assert property (wr_ctl |=> o_coder_bypass ==
    ($past(i_reg_wdata[15]) && $past(i_reg_wdata[4])) && o_scrambler_bypass ==
    ($past(i_reg_wdata[15]) && $past(i_reg_wdata[3]))) else $error("bypass gating wrong");
  a_partner_rsvd_zero: assert property (rd_go && i_reg_addr == 8'hc5 |=> !o_reg_rdata[12])
    else $error("partner reserved bit set");
  a_remote_fault_copy: assert property (i_ce && i_lp_page_valid |=>
    o_remote_fault_status == $past(i_lp_page[13])) else $error("remote fault status wrong");
  a_local_np_one: assert property (rd_c6 |=> o_reg_rdata[2])
    else $error("local next page bit low");
  a_unmapped_zero: assert property (rd_go && !mapped |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_gmask_silences: assert property (wr_int && i_reg_wdata[13] |=> !o_int)
    else $error("interrupt despite global mask");
  a_page_rx_latch: assert property (i_ce && i_lp_page_valid ##1 !rd_c6 ##1 rd_c6
    |=> o_reg_rdata[1]) else $error("page received not latched");
  // main scenarios reached
  c_ctl_write: cover property (wr_ctl);
  c_page_in: cover property (i_ce && i_lp_page_valid);
  c_irq: cover property (o_int);
endmodule // cpar_regs_monitor

bind cpar_regs cpar_regs_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cpar_regs_monitor_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_lp_page_valid(i_lp_page_valid),
  .i_lp_page(i_lp_page), .o_adv_page(o_adv_page), .o_remote_fault_status(o_remote_fault_status),
  .o_auto_xover_en(o_auto_xover_en), .o_fef_en(o_fef_en), .o_power_save_en(o_power_save_en),
  .o_normal_link_pulse_en(o_normal_link_pulse_en), .o_dsp_restart_bypass(o_dsp_restart_bypass),
  .o_coder_bypass(o_coder_bypass), .o_scrambler_bypass(o_scrambler_bypass), .o_int(o_int));

// >>> dv/cpar_mgr_model.sv
// management controller model driving the register port
`timescale 1ns/1ns
module cpar_mgr_model (
  input wire i_clk,
  input wire [15:0] i_reg_rdata,
  input wire i_reg_rvalid,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [15:0] o_reg_wdata,
  output logic o_reg_rd
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 16'h0000;
    o_reg_rd = 1'b0;
  end
  // =====================================================================
  // one write; raw lets a scenario set bits a careful manager keeps zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit raw);
    logic [15:0] x;
    x = d;
    if (!raw && a == 8'hc4) x = x & 16'hafff;
    if (!raw && a == 8'hd0) x = x & 16'h0ff8;
    @(posedge i_clk);
    #1 o_reg_addr = a;
    o_reg_wdata = x;
    o_reg_wr = 1'b1;
    @(posedge i_clk);
    #1 o_reg_wr = 1'b0;
    o_reg_addr = ~a; // released lines show garbage, not the old value
    o_reg_wdata = ~x;
  endtask
  // one read; data goes unknown when no valid came back
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    #1 o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(posedge i_clk);
    #1 o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
  endtask
endmodule // cpar_mgr_model

// >>> dv/testbench.sv
// self-checking bench for the copper port negotiation register bank
`timescale 1ns/1ns
module testbench;
  logic clk, rst, ce, pg_v, pdf, an, lnk, dup, spd, pwr, wr, rd;
  logic [7:0] addr;
  logic [15:0] wd, pg, v, w, e;
  wire [15:0] rdata, adv;
  wire rvalid, rfs, xo, hb, jb, fef, ps, lpe, rsb, cb, sb, irq;
  wire [15:0] outs = {7'h00, xo, hb, jb, fef, ps, lpe, rsb, cb, sb};
  int fails, num_checks;
  logic [7:0] ra [5] = '{8'hc4, 8'hc5, 8'hc6, 8'hd0, 8'hd1};
  logic [15:0] rv [5] = '{16'h05e1, 16'h0000, 16'h0004, 16'h0000, 16'h3f00};
  logic [7:0] ua [6] = '{8'hc7, 8'hc8, 8'hc9, 8'hcf, 8'h00, 8'hff};
  cpar_regs cpar_regs_i (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_lp_page_valid(pg_v), .i_lp_page(pg), .i_pd_fault(pdf), .i_lp_an_able(an),
    .i_link_up(lnk), .i_full_duplex(dup), .i_speed_100(spd), .i_remote_power_abn(pwr),
    .o_adv_page(adv), .o_remote_fault_status(rfs), .o_auto_xover_en(xo), .o_heartbeat_en(hb),
    .o_jabber_en(jb), .o_fef_en(fef), .o_power_save_en(ps), .o_normal_link_pulse_en(lpe),
    .o_dsp_restart_bypass(rsb), .o_coder_bypass(cb), .o_scrambler_bypass(sb), .o_int(irq));
  cpar_mgr_model m (.i_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_addr(addr),
    .o_reg_wr(wr), .o_reg_wdata(wd), .o_reg_rd(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // =====================================================================
  // checking helpers
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [15:0] ctl_outs(input logic [15:0] c);
    return {7'h00, !c[11], c[10], c[9], !c[8], !c[7], !c[6], c[5], c[15] & c[4], c[15] & c[3]};
  endfunction
  // one-cycle event on a status input, raised just after an edge
  task automatic tick(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  // =====================================================================
  // main sequence
  initial begin
    {rst, ce, pg_v, pdf, an, lnk, dup, spd, pwr} = 9'h180;
    pg = 16'h0000;
    v = $urandom(51);
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    cmp16(adv, 16'h05e1);
    cmp16(outs, ctl_outs(16'h0000));
    cmp16({14'h0, rfs, irq}, 16'h0000);
    foreach (ra[i]) begin
      m.rd(ra[i], v);
      cmp16(v, rv[i]);
    end
    // control word: gated bypass corners first, then random
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'h8018 : (i == 1) ? 16'h0018 : 16'($urandom);
      e = (i < 6) ? w : (w & 16'h0ff8);
      m.wr(8'hd0, w, i < 6);
      cmp16(outs, ctl_outs(e));
      m.rd(8'hd0, v);
      cmp16(v, e);
    end
    // a frozen clock enable must drop the write
    ce = 1'b0;
    m.wr(8'hd0, ~e, 1'b1);
    ce = 1'b1;
    cmp16(outs, ctl_outs(e));
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hffff : 16'($urandom);
      m.wr(8'hc4, w, i[0]);
      cmp16(adv, w & 16'h2fff);
      m.rd(8'hc4, v);
      cmp16(v, w & 16'h2fff);
    end
    // partner pages: capture, fault copy, latch and clear on read
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hffff : 16'($urandom);
      an = w[0];
      pg = w;
      tick(pg_v);
      m.rd(8'hc6, v);
      cmp16(v, {12'h0, w[15], 3'b110} | {15'h0, w[0]});
      m.wr(8'hc5, ~w, 1'b1);
      cmp16({15'h0, rfs}, {15'h0, w[13]});
      m.rd(8'hc5, v);
      cmp16(v, w & 16'hefff);
      m.rd(8'hc6, v);
      cmp16(v, {12'h0, w[15], 3'b100} | {15'h0, w[0]});
    end
    tick(pdf);
    m.rd(8'hc6, v);
    cmp16(v & 16'h0010, 16'h0010);
    m.rd(8'hc6, v);
    cmp16(v & 16'h0010, 16'h0000);
    // interrupts: unmasked link change, then everything masked globally
    m.wr(8'hd1, 16'h0600, 1'b1);
    tick(lnk);
    cmp16({15'h0, irq}, 16'h0001);
    m.rd(8'hd1, v);
    cmp16(v, 16'h1e21);
    m.rd(8'hd1, v);
    cmp16(v, 16'h1e00);
    m.wr(8'hd1, 16'h2000, 1'b1);
    dup = 1'b1;
    spd = 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp16({15'h0, irq}, 16'h0000);
    m.rd(8'hd1, v);
    cmp16(v, 16'h3826);
    m.wr(8'hd1, 16'h0080, 1'b1);
    tick(pwr);
    cmp16({15'h0, irq}, 16'h0001);
    m.rd(8'hd1, v);
    cmp16(v, 16'h18c0);
    foreach (ua[i]) begin
      m.wr(ua[i], 16'hffff, 1'b1);
      m.rd(ua[i], v);
      cmp16(v, 16'h0000);
    end
    tally_and_finish();
  end
endmodule // testbench
